// ==== core/iosem_pkg.sv ====
// Shared types and constants for the instruction operand semantics decoder
package iosem_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int unsigned WORD_W = 32;
  localparam int unsigned HALF_W = 16;
  localparam int unsigned CP_COUNT = 16;

  // ----------------------------------------------------------------
  // Program status word layout and reset value
  // ----------------------------------------------------------------
  localparam int unsigned PSW_FLAGS_LSB = 28;
  localparam int unsigned PSW_E_BIT = 9;
  localparam int unsigned PSW_A_BIT = 8;
  localparam int unsigned PSW_I_BIT = 7;
  localparam int unsigned PSW_F_BIT = 6;
  localparam logic [31:0] PSW_RESET = 32'h000001D3;

  // ----------------------------------------------------------------
  // Flag list positions inside the decoded interrupt flag field
  // ----------------------------------------------------------------
  localparam int unsigned IFLAG_F = 0;
  localparam int unsigned IFLAG_I = 1;
  localparam int unsigned IFLAG_A = 2;

  // ----------------------------------------------------------------
  // Operand constants
  // ----------------------------------------------------------------
  localparam logic [5:0] ASR_ZERO_AMOUNT = 6'h20;
  localparam logic [3:0] HIGH_REG_BASE = 4'h8;
  localparam logic [3:0] LOW_REG_BASE = 4'h0;

  // ----------------------------------------------------------------
  // Instruction classes
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    KIND_NONE = 3'h0,
    KIND_DATA = 3'h1,
    KIND_MEM_SINGLE = 3'h2,
    KIND_MEM_MULTI = 3'h3,
    KIND_STATE_CHANGE = 3'h4,
    KIND_SET_ENDIAN = 3'h5,
    KIND_COPROC = 3'h6
  } iosem_kind_type;

  // Writeback sequencer states, one-hot
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_WAIT = 3'b010,
    ST_DONE = 3'b100
  } iosem_state_type;

  // Decoded options of one instruction
  typedef struct packed {
    iosem_kind_type kind;
    logic writeback;
    logic user_bank;
    logic loads_pc;
    logic is_load;
    logic translate;
    logic pre_indexed;
    logic [3:0] base_reg;
    logic x_top;
    logic y_top;
    logic effect_en;
    logic effect_disable;
    logic [2:0] iflags;
    logic endian_be;
    logic set_flags;
    logic shift_type;
    logic [4:0] shift_imm;
    logic [1:0] ext_rot;
    logic [3:0] imm_rot;
    logic [7:0] imm8;
    logic [3:0] coprocessor_number;
    logic [7:0] cp_option;
    logic [2:0] high_reg;
    logic [2:0] low_reg;
  } iosem_ctrl_type;

endpackage : iosem_pkg

// ==== core/iosem_rotr.sv ====
// Combinational 32-bit rotate right by a variable amount
module iosem_rotr (
  // Data in
  input wire logic [31:0] i_data,
  input wire logic [4:0] i_amount,
  // Data out
  output logic [31:0] o_data
);

  // ----------------------------------------------------------------
  // Rotation
  // ----------------------------------------------------------------
  logic [63:0] dbl;

  // Doubling the word turns the wrap-around into a plain index
  assign dbl = {i_data, i_data};

  // Each result bit picks its source from the doubled word
  for (genvar g = 0; g < 32; g++) begin : g_bit
    assign o_data[g] = dbl[g + i_amount];
  end

endmodule : iosem_rotr

// ==== core/iosem_shifter.sv ====
// Combinational immediate shifter: logical left or arithmetic right
module iosem_shifter (
  // Operand and shift option
  input wire logic [31:0] i_data,
  input wire logic i_type,
  input wire logic [4:0] i_imm,
  // Result
  output logic [31:0] o_data,
  output logic [5:0] o_amount
);

  // ----------------------------------------------------------------
  // Amount and shift
  // ----------------------------------------------------------------
  // for an arithmetic shift, zero means thirty-two
  assign o_amount = (i_type && (i_imm == 5'h00)) ? iosem_pkg::ASR_ZERO_AMOUNT : {1'b0, i_imm};

  assign o_data = i_type ? 32'($signed(i_data) >>> o_amount) : 32'(i_data << o_amount);

endmodule : iosem_shifter

// ==== core/iosem_decoder.sv ====
// Operand and option decoder between fetch and execute
//
// Contract
// - Writeback updates base after access completes
// - User-bank option transfers user banked registers, except on a multiple load of pc
// - Multiple load of pc with user-bank option restores saved status
// - Translation forces user privilege, not pre-indexed
// - First selector picks top or bottom half
// - Second selector picks shift source half
// - Route coprocessor operation to numbered unit
// - Effect enables or disables listed mask bits
// - Flag list non-empty, exactly those bits change
// - Endian setting drives instruction and status bit
// - Scaled immediate is eight bits times four
// - Rotated immediate rotates eight bits evenly
// - High register operands select R8 to R15
// - Low register operands select R0 to R7
// - Coprocessor option passed as 0 to 255
// - Extend rotation by 8, 16 or 24
// - Shift type picks left or arithmetic right
// - Set-flags updates condition flags from result
module iosem_decoder (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_srst,
  // Instruction request from decode
  input wire logic i_valid,
  input wire iosem_pkg::iosem_ctrl_type i_ctrl,
  input wire logic [31:0] i_first_operand_register,
  input wire logic [31:0] i_shift_source_register,
  // Feedback from execute and memory
  input wire logic [31:0] i_computed_address,
  input wire logic i_mem_done,
  input wire logic i_result_valid,
  input wire logic [3:0] i_result_flags,
  input wire logic [31:0] i_saved_program_status,
  // Request handshake
  output logic o_ready,
  output logic o_out_valid,
  output logic o_illegal,
  output iosem_pkg::iosem_kind_type o_kind,
  // Operand values
  output logic [15:0] o_half_first,
  output logic [15:0] o_half_shift,
  output logic [9:0] o_scaled_imm,
  output logic [31:0] o_rotated_immediate,
  output logic [31:0] o_ext_rotated,
  output logic [31:0] o_shift_result,
  output logic [5:0] o_shift_amount,
  output logic o_shift_arith,
  output logic [3:0] o_high_reg_idx,
  output logic [3:0] o_low_reg_idx,
  // Coprocessor routing
  output logic [15:0] o_cp_select,
  output logic [7:0] o_cp_option,
  // Memory access options
  output logic o_mem_start,
  output logic o_user_bank,
  output logic o_user_priv,
  output logic o_base_wb_en,
  output logic [3:0] o_base_wb_idx,
  output logic [31:0] o_base_wb_addr,
  // Status
  output logic o_status_restore,
  output logic o_flags_we,
  output logic o_e_bit,
  output logic [31:0] o_program_status_word
);

  // ----------------------------------------------------------------
  // Request acceptance and legality
  // ----------------------------------------------------------------
  iosem_pkg::iosem_state_type state_r;
  iosem_pkg::iosem_state_type state_nxt;
  logic ready_r;
  logic take;
  logic is_mem;
  logic is_multi;
  logic bad_translate;
  logic bad_iflags;
  logic legal;
  logic mem_go;

  // Requests are taken only while no memory access is outstanding
  assign take = i_valid && ready_r;
  assign is_multi = (i_ctrl.kind == iosem_pkg::KIND_MEM_MULTI);
  assign is_mem = (i_ctrl.kind == iosem_pkg::KIND_MEM_SINGLE) || is_multi;

  assign bad_translate = (i_ctrl.kind == iosem_pkg::KIND_MEM_SINGLE) && i_ctrl.translate && i_ctrl.pre_indexed;

  assign bad_iflags = (i_ctrl.kind == iosem_pkg::KIND_STATE_CHANGE) && i_ctrl.effect_en && (i_ctrl.iflags == 3'h0);

  // An illegal instruction starts no access and changes no status bit; operand outputs still update
  assign legal = !bad_translate && !bad_iflags;
  assign mem_go = take && legal && is_mem;

  // ----------------------------------------------------------------
  // Operand datapath
  // ----------------------------------------------------------------
  logic [31:0] imm_rot_data;
  logic [31:0] ext_rot_data;
  logic [31:0] shift_data;
  logic [5:0] shift_amt;
  logic [4:0] imm_rot_amt;
  logic [4:0] ext_rot_amt;

  assign imm_rot_amt = {i_ctrl.imm_rot, 1'b0};

  assign ext_rot_amt = {i_ctrl.ext_rot, 3'b000};

  // Rotated immediate from the 8-bit field
  iosem_rotr u_imm_rot (
    .i_data({24'h000000, i_ctrl.imm8}),
    .i_amount(imm_rot_amt),
    .o_data(imm_rot_data)
  );

  // Extend source rotation; a zero field means no rotation option
  iosem_rotr u_ext_rot (
    .i_data(i_first_operand_register),
    .i_amount(ext_rot_amt),
    .o_data(ext_rot_data)
  );

  // Immediate shift of the first operand
  iosem_shifter u_shift (
    .i_data(i_first_operand_register),
    .i_type(i_ctrl.shift_type),
    .i_imm(i_ctrl.shift_imm),
    .o_data(shift_data),
    .o_amount(shift_amt)
  );

  // Operand outputs are registered at each taken request
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      o_half_first <= 16'h0000;
      o_half_shift <= 16'h0000;
      o_scaled_imm <= 10'h000;
      o_rotated_immediate <= 32'h00000000;
      o_ext_rotated <= 32'h00000000;
      o_shift_result <= 32'h00000000;
      o_shift_amount <= 6'h00;
      o_shift_arith <= 1'b0;
      o_high_reg_idx <= iosem_pkg::HIGH_REG_BASE;
      o_low_reg_idx <= iosem_pkg::LOW_REG_BASE;
    end else if (take) begin
      o_half_first <= i_ctrl.x_top ? i_first_operand_register[31:16] : i_first_operand_register[15:0];
      o_half_shift <= i_ctrl.y_top ? i_shift_source_register[31:16] : i_shift_source_register[15:0];
      o_scaled_imm <= {i_ctrl.imm8, 2'b00};
      o_rotated_immediate <= imm_rot_data;
      o_ext_rotated <= ext_rot_data;
      o_shift_result <= shift_data;
      o_shift_amount <= shift_amt;
      o_shift_arith <= i_ctrl.shift_type;
      o_high_reg_idx <= iosem_pkg::HIGH_REG_BASE | {1'b0, i_ctrl.high_reg};
      o_low_reg_idx <= iosem_pkg::LOW_REG_BASE | {1'b0, i_ctrl.low_reg};
    end
  end

  // ----------------------------------------------------------------
  // Request status outputs
  // ----------------------------------------------------------------
  // Valid and kind pulse for one cycle after each taken request
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      o_out_valid <= 1'b0;
      o_illegal <= 1'b0;
      o_kind <= iosem_pkg::KIND_NONE;
    end else begin
      o_out_valid <= take;
      o_illegal <= take && !legal;
      o_kind <= take ? i_ctrl.kind : iosem_pkg::KIND_NONE;
    end
  end

  // ----------------------------------------------------------------
  // Coprocessor routing
  // ----------------------------------------------------------------
  logic [15:0] cp_sel_nxt;

  for (genvar g = 0; g < iosem_pkg::CP_COUNT; g++) begin : g_cp
    assign cp_sel_nxt[g] = take && (i_ctrl.kind == iosem_pkg::KIND_COPROC) && (i_ctrl.coprocessor_number == 4'(g));
  end

  // Select is a one-cycle pulse; the option value holds until the next coprocessor request
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      o_cp_select <= 16'h0000;
      o_cp_option <= 8'h00;
    end else begin
      o_cp_select <= cp_sel_nxt;
      if (take && (i_ctrl.kind == iosem_pkg::KIND_COPROC)) begin
        o_cp_option <= i_ctrl.cp_option;
      end
    end
  end

  // ----------------------------------------------------------------
  // Memory access options
  // ----------------------------------------------------------------
  // Privilege and bank options are held for the whole access
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      o_mem_start <= 1'b0;
      o_user_bank <= 1'b0;
      o_user_priv <= 1'b0;
    end else begin
      o_mem_start <= mem_go;
      if (mem_go) begin
        o_user_bank <= is_multi && i_ctrl.user_bank && !(i_ctrl.is_load && i_ctrl.loads_pc);
        o_user_priv <= !is_multi && i_ctrl.translate;
      end else if (state_r == iosem_pkg::ST_DONE) begin
        o_user_bank <= 1'b0;
        o_user_priv <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Completion sequencer
  // ----------------------------------------------------------------
  logic wb_pend_r;
  logic restore_pend_r;
  logic [3:0] wb_idx_r;

  // Next state: wait for the access to finish, then one settle cycle
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      iosem_pkg::ST_IDLE: begin
        if (mem_go) begin
          state_nxt = iosem_pkg::ST_WAIT;
        end
      end
      iosem_pkg::ST_WAIT: begin
        if (i_mem_done) begin
          state_nxt = iosem_pkg::ST_DONE;
        end
      end
      iosem_pkg::ST_DONE: begin
        state_nxt = iosem_pkg::ST_IDLE;
      end
      default: begin
        state_nxt = iosem_pkg::ST_IDLE;
      end
    endcase
  end

  // State register and ready; ready is the registered idle look-ahead
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      state_r <= iosem_pkg::ST_IDLE;
      ready_r <= 1'b1;
    end else begin
      state_r <= state_nxt;
      ready_r <= (state_nxt == iosem_pkg::ST_IDLE);
    end
  end

  assign o_ready = ready_r;

  // Options of the outstanding access are captured at acceptance
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      wb_pend_r <= 1'b0;
      restore_pend_r <= 1'b0;
      wb_idx_r <= 4'h0;
    end else if (mem_go) begin
      wb_pend_r <= i_ctrl.writeback;
      restore_pend_r <= is_multi && i_ctrl.is_load && i_ctrl.loads_pc && i_ctrl.user_bank;
      wb_idx_r <= i_ctrl.base_reg;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      o_base_wb_en <= 1'b0;
      o_base_wb_idx <= 4'h0;
      o_base_wb_addr <= 32'h00000000;
    end else begin
      o_base_wb_en <= (state_r == iosem_pkg::ST_WAIT) && i_mem_done && wb_pend_r;
      if ((state_r == iosem_pkg::ST_WAIT) && i_mem_done) begin
        o_base_wb_idx <= wb_idx_r;
        o_base_wb_addr <= i_computed_address;
      end
    end
  end

  // ----------------------------------------------------------------
  // Condition flag tracking
  // ----------------------------------------------------------------
  logic flags_pend_r;
  logic flags_upd;

  assign flags_upd = i_result_valid && flags_pend_r;

  // A new set-flags request wins over the clear by a result
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      flags_pend_r <= 1'b0;
    end else if (take && legal && i_ctrl.set_flags && (i_ctrl.kind == iosem_pkg::KIND_DATA)) begin
      flags_pend_r <= 1'b1;
    end else if (i_result_valid) begin
      flags_pend_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Program status word
  // ----------------------------------------------------------------
  logic [31:0] psw_r;
  logic [31:0] psw_nxt;
  logic mask_go;
  logic endian_go;
  logic restore_go;

  assign mask_go = take && legal && (i_ctrl.kind == iosem_pkg::KIND_STATE_CHANGE) && i_ctrl.effect_en;
  assign endian_go = take && legal && (i_ctrl.kind == iosem_pkg::KIND_SET_ENDIAN);
  assign restore_go = (state_r == iosem_pkg::ST_WAIT) && i_mem_done && restore_pend_r;

  // Later assignments win; a restore replaces the whole word
  always_comb begin
    psw_nxt = psw_r;
    if (flags_upd) begin
      psw_nxt[iosem_pkg::PSW_FLAGS_LSB +: 4] = i_result_flags;
    end
    if (mask_go) begin
      if (i_ctrl.iflags[iosem_pkg::IFLAG_A]) begin
        psw_nxt[iosem_pkg::PSW_A_BIT] = i_ctrl.effect_disable;
      end
      if (i_ctrl.iflags[iosem_pkg::IFLAG_I]) begin
        psw_nxt[iosem_pkg::PSW_I_BIT] = i_ctrl.effect_disable;
      end
      if (i_ctrl.iflags[iosem_pkg::IFLAG_F]) begin
        psw_nxt[iosem_pkg::PSW_F_BIT] = i_ctrl.effect_disable;
      end
    end
    if (endian_go) begin
      psw_nxt[iosem_pkg::PSW_E_BIT] = i_ctrl.endian_be;
    end
    if (restore_go) begin
      psw_nxt = i_saved_program_status;
    end
  end

  // Status word and its side pulses
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      psw_r <= iosem_pkg::PSW_RESET;
      o_status_restore <= 1'b0;
      o_flags_we <= 1'b0;
    end else begin
      psw_r <= psw_nxt;
      o_status_restore <= restore_go;
      o_flags_we <= flags_upd;
    end
  end

  assign o_program_status_word = psw_r;

  // ----------------------------------------------------------------
  // Instruction endian bit
  // ----------------------------------------------------------------
  // instruction endian bit
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      o_e_bit <= 1'b0;
    end else if (endian_go) begin
      o_e_bit <= i_ctrl.endian_be;
    end
  end

endmodule : iosem_decoder

// ==== bench/iosem_decoder_asserts.sv ====
// Port-level checker for the operand semantics decoder
module iosem_decoder_asserts (
  // Clock, reset and request side
  input wire logic i_mclk, i_srst, i_valid, i_mem_done,
  input wire iosem_pkg::iosem_ctrl_type i_ctrl,
  input wire logic [31:0] i_first_operand_register, i_shift_source_register, i_computed_address,
  // Watched outputs
  input wire logic o_ready, o_out_valid, o_base_wb_en, o_flags_we, o_status_restore, o_shift_arith,
  input wire logic [15:0] o_half_first, o_half_shift, o_cp_select,
  input wire logic [9:0] o_scaled_imm,
  input wire logic [7:0] o_cp_option,
  input wire logic [5:0] o_shift_amount,
  input wire logic [3:0] o_high_reg_idx, o_low_reg_idx,
  input wire logic [31:0] o_base_wb_addr, o_program_status_word
);
  timeunit 1ns;
  timeprecision 1ns;
  // One clock domain, so clock and disable are given once
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_srst);

  // ------------------------------------------------------------
  // Request steps
  // ------------------------------------------------------------
  sequence s_take;
    i_valid && o_ready;
  endsequence
  sequence s_cp_take;
    s_take ##0 (i_ctrl.kind == iosem_pkg::KIND_COPROC);
  endsequence
  sequence s_asr0_take;
    s_take ##0 (i_ctrl.shift_type && i_ctrl.shift_imm == 5'h00);
  endsequence

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  a_take_answer: assert property (s_take |=> o_out_valid) else $error("no answer after take");
  a_half_first: assert property (s_take |=> o_half_first == ($past(i_ctrl.x_top) ?
    $past(i_first_operand_register[31:16]) : $past(i_first_operand_register[15:0]))) else $error("first half wrong");
  a_half_shift: assert property (s_take |=> o_half_shift == ($past(i_ctrl.y_top) ?
    $past(i_shift_source_register[31:16]) : $past(i_shift_source_register[15:0]))) else $error("shift half wrong");
  a_scaled_imm: assert property (s_take |=> o_scaled_imm == {$past(i_ctrl.imm8), 2'b00})
    else $error("scaled immediate wrong");
  a_asr_zero: assert property (s_asr0_take |=> o_shift_arith && o_shift_amount == 6'h20)
    else $error("zero arithmetic amount not 32");
  a_cp_route: assert property (s_cp_take |=> o_cp_select == (16'h0001 << $past(i_ctrl.coprocessor_number)))
    else $error("coprocessor select wrong");
  a_cp_option: assert property (s_cp_take |=> o_cp_option == $past(i_ctrl.cp_option))
    else $error("coprocessor option wrong");
  a_high_reg: assert property (s_take |=> o_high_reg_idx == {1'b1, $past(i_ctrl.high_reg)})
    else $error("high register index wrong");
  a_low_reg: assert property (s_take |=> o_low_reg_idx == {1'b0, $past(i_ctrl.low_reg)})
    else $error("low register index wrong");
  a_flags_only: assert property (!$stable(o_program_status_word[31:28]) |-> o_flags_we || o_status_restore)
    else $error("flags changed without update");
  a_wb_done: assert property (o_base_wb_en |-> $past(i_mem_done) && !$past(o_ready) &&
    o_base_wb_addr == $past(i_computed_address)) else $error("base writeback not after completion");
endmodule : iosem_decoder_asserts

bind iosem_decoder iosem_decoder_asserts i_iosem_decoder_asserts (.*);

// ==== bench/tb_iosem_decoder.sv ====
// Self-checking bench for the operand semantics decoder
module tb_iosem_decoder;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_mclk, i_srst, i_valid, i_mem_done, i_result_valid;
  iosem_pkg::iosem_ctrl_type i_ctrl, c;
  logic [31:0] i_first_operand_register, i_shift_source_register, i_computed_address, i_saved_program_status;
  logic [3:0] i_result_flags;
  logic o_ready, o_out_valid, o_illegal, o_shift_arith, o_mem_start, o_user_bank, o_user_priv, o_base_wb_en;
  logic o_status_restore, o_flags_we, o_e_bit;
  iosem_pkg::iosem_kind_type o_kind;
  logic [15:0] o_half_first, o_half_shift, o_cp_select;
  logic [9:0] o_scaled_imm;
  logic [31:0] o_rotated_immediate, o_ext_rotated, o_shift_result, o_base_wb_addr, o_program_status_word;
  logic [5:0] o_shift_amount;
  logic [3:0] o_high_reg_idx, o_low_reg_idx, o_base_wb_idx;
  logic [7:0] o_cp_option;
  logic [31:0] exp_psw, a, b, m;
  int mismatches, cmp_count, seed;

  iosem_decoder i_iosem_decoder (.*);

  // 20 MHz clock
  initial begin
    i_mclk = 1'b0;
    forever #25 i_mclk = ~i_mclk;
  end

  // ------------------------------------------------------------
  // Reference model and drivers
  // ------------------------------------------------------------
  function automatic logic [31:0] rotr(input logic [31:0] d, input int n);
    logic [63:0] w;
    w = {d, d} >> n;
    return w[31:0];
  endfunction : rotr

  // Arithmetic amount 0 stands for 32, so a 64-bit sign extension is used
  function automatic logic [31:0] shf(input logic [31:0] d, input logic t, input int n);
    logic [63:0] w;
    if (!t) return d << n;
    w = $signed({{32{d[31]}}, d}) >>> ((n == 0) ? 32 : n);
    return w[31:0];
  endfunction : shf

  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", n, exp, seen);
    end
  endtask : chk

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : finish_test

  // Bounded wait, entered and left 5 ns after an edge
  task automatic wait_ready();
    for (int n = 0; o_ready !== 1'b1; n++) begin
      if (n == 20) begin
        mismatches++;
        finish_test();
      end
      @(posedge i_mclk);
      #5;
    end
  endtask : wait_ready

  // Valid stays up so calls run back to back; drop() lowers it
  task automatic issue(input iosem_pkg::iosem_ctrl_type t);
    i_ctrl = t;
    i_first_operand_register = a;
    i_shift_source_register = b;
    i_valid = 1'b1;
    wait_ready();
    @(posedge i_mclk);
    #5;
  endtask : issue

  task automatic drop();
    i_valid = 1'b0;
    @(posedge i_mclk);
    #5;
  endtask : drop

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    i_srst = 1'b1;
    i_valid = 1'b0;
    i_ctrl = '0;
    a = 32'h0;
    b = 32'h0;
    i_first_operand_register = 32'h0;
    i_shift_source_register = 32'h0;
    i_computed_address = 32'h0;
    i_saved_program_status = 32'h0;
    i_mem_done = 1'b0;
    i_result_valid = 1'b0;
    i_result_flags = 4'h0;
    mismatches = 0;
    cmp_count = 0;
    seed = $urandom(32'h1280);
    exp_psw = iosem_pkg::PSW_RESET;
    repeat (2) @(posedge i_mclk);
    #5;
    i_srst = 1'b0;
    chk("ready", o_ready, 1);
    chk("psw", o_program_status_word, exp_psw);
    chk("high_idx", o_high_reg_idx, 4'h8);
    $display("test reset done");
    // Random data operands, the first two with a zero shift field
    for (int k = 0; k < 40; k++) begin
      c = 60'({$urandom, $urandom});
      c.kind = iosem_pkg::KIND_DATA;
      c.set_flags = 1'b0;
      if (k < 2) begin
        c.shift_type = k[0];
        c.shift_imm = 5'h00;
      end
      a = $urandom;
      b = $urandom;
      issue(c);
      chk("kind", o_kind, iosem_pkg::KIND_DATA);
      chk("half_first", o_half_first, c.x_top ? a[31:16] : a[15:0]);
      chk("half_shift", o_half_shift, c.y_top ? b[31:16] : b[15:0]);
      chk("scaled", o_scaled_imm, {c.imm8, 2'b00});
      chk("rot_imm", o_rotated_immediate, rotr({24'h0, c.imm8}, {c.imm_rot, 1'b0}));
      chk("ext_rot", o_ext_rotated, rotr(a, {c.ext_rot, 3'b000}));
      chk("shift", o_shift_result, shf(a, c.shift_type, c.shift_imm));
      chk("shift_amt", o_shift_amount, (c.shift_type && c.shift_imm == 0) ? 32 : c.shift_imm);
      chk("arith", o_shift_arith, c.shift_type);
      chk("high_idx", o_high_reg_idx, 8 + c.high_reg);
      chk("low_idx", o_low_reg_idx, c.low_reg);
    end
    $display("test operands done");
    // Every coprocessor number, option at both ends of its range
    for (int k = 0; k < 16; k++) begin
      c = '0;
      c.kind = iosem_pkg::KIND_COPROC;
      c.coprocessor_number = k[3:0];
      c.cp_option = (k == 0) ? 8'h00 : (k == 15) ? 8'hFF : 8'($urandom);
      issue(c);
      chk("cp_select", o_cp_select, 16'h0001 << k);
      chk("cp_option", o_cp_option, c.cp_option);
    end
    $display("test coprocessor done");
    // Enable then disable each flag list, empty list refused
    for (int k = 0; k < 16; k++) begin
      c = '0;
      c.kind = iosem_pkg::KIND_STATE_CHANGE;
      c.effect_en = 1'b1;
      c.effect_disable = k[3];
      c.iflags = k[2:0];
      issue(c);
      m = 32'(k[2:0]) << iosem_pkg::PSW_F_BIT;
      if (k[2:0] != 3'h0) exp_psw = k[3] ? (exp_psw | m) : (exp_psw & ~m);
      chk("illegal", o_illegal, k[2:0] == 3'h0);
      chk("psw", o_program_status_word, exp_psw);
    end
    // Endian big, little, big
    for (int k = 0; k < 3; k++) begin
      c = '0;
      c.kind = iosem_pkg::KIND_SET_ENDIAN;
      c.endian_be = ~k[0];
      issue(c);
      exp_psw[iosem_pkg::PSW_E_BIT] = ~k[0];
      chk("e_bit", o_e_bit, !k[0]);
      chk("psw", o_program_status_word, exp_psw);
    end
    $display("test status done");
    // Result flags land only after a set-flags request
    for (int k = 0; k < 2; k++) begin
      c = '0;
      c.kind = iosem_pkg::KIND_DATA;
      c.set_flags = ~k[0];
      issue(c);
      drop();
      i_result_flags = 4'($urandom);
      i_result_valid = 1'b1;
      @(posedge i_mclk);
      #5;
      i_result_valid = 1'b0;
      if (k == 0) exp_psw[31:28] = i_result_flags;
      chk("flags_we", o_flags_we, !k[0]);
      chk("psw", o_program_status_word, exp_psw);
    end
    $display("test flags done");
    // Memory: translated store, refused pre-indexed, user bank, status restore
    for (int k = 0; k < 4; k++) begin
      c = '0;
      c.kind = (k < 2) ? iosem_pkg::KIND_MEM_SINGLE : iosem_pkg::KIND_MEM_MULTI;
      c.writeback = (k != 2);
      c.translate = (k < 2);
      c.pre_indexed = (k == 1);
      c.user_bank = (k > 1);
      c.is_load = (k == 3);
      c.loads_pc = (k == 3);
      c.base_reg = 4'($urandom);
      issue(c);
      chk("illegal", o_illegal, k == 1);
      chk("mem_start", o_mem_start, k != 1);
      chk("user_priv", o_user_priv, k == 0);
      chk("user_bank", o_user_bank, k == 2);
      drop();
      if (k != 1) begin
        i_computed_address = $urandom;
        i_saved_program_status = $urandom;
        i_mem_done = 1'b1;
        @(posedge i_mclk);
        #5;
        i_mem_done = 1'b0;
        if (k == 3) exp_psw = i_saved_program_status;
        chk("wb_en", o_base_wb_en, k != 2);
        if (k != 2) chk("wb_addr", o_base_wb_addr, i_computed_address);
        if (k != 2) chk("wb_idx", o_base_wb_idx, c.base_reg);
        chk("restore", o_status_restore, k == 3);
        chk("psw", o_program_status_word, exp_psw);
        wait_ready();
      end
    end
    $display("test memory done");
    finish_test();
  end
endmodule : tb_iosem_decoder
